// File: rtl/mcs_sequencer.sv
// Microcoded sequencer: next-address logic, outputs, counters, APB slave.
// Assumes data-plane inputs share pclk; memories are loaded over APB.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module mcs_sequencer (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic [11:0]               paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire mcs_pkg::mcs_input_type    data_in,
    input  wire mcs_pkg::mcs_case_type     case_in,
    output mcs_pkg::mcs_state_type         state_out,
    output mcs_pkg::mcs_case_sel_type      case_sel
);
    import mcs_pkg::*;

    typedef struct packed {
        mcs_addr_type                       pc;
        mcs_state_type                      outs;
        logic [NUM_TIMERS-1:0][TIMER_W-1:0] cnt;
        logic                               run;
        logic [HI_W-1:0]                    hi;
        logic [LOAD_SEL_W-1:0]              load_sel;
        logic [31:0]                        rdata;
        logic                               slverr;
    } mcs_core_type;

    mcs_core_type r_q;
    mcs_core_type r_d;

    // ************************************************************
    // Memories
    // ************************************************************
    logic [UWORD_W-1:0] ucode_mem [UCODE_DEPTH];
    logic               expr_mem  [EXPR_DEPTH];
    mcs_count_type      timer_mem [TIMER_DEPTH];
    mcs_addr_type       case_mem  [CASE_DEPTH];

    mcs_uword_type          uw;
    logic                   expr_bit;
    mcs_count_type          timer_word;
    mcs_addr_type           case_word;
    mcs_addr_type           case_idx;
    logic [NUM_TIMERS-1:0]  done;
    logic                   cond;
    logic                   push;
    logic                   pop;
    logic                   restart;
    mcs_addr_type           stack_top;
    logic [DEPTH_W-1:0]     stack_depth;
    logic                   setup;
    logic                   access_wr;
    logic                   load_wr;
    logic [1:0]             load_mem;
    logic [ADDR_W-1:0]      load_idx;
    mcs_addr_type           pc_inc;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == REG_CTRL) || (a == REG_STATUS) ||
                 (a == REG_LOAD_SEL) || (a == REG_LOAD_LO) ||
                 (a == REG_LOAD_HI);
    endfunction

    assign uw       = mcs_uword_type'(ucode_mem[r_q.pc]);
    assign expr_bit = expr_mem[{uw.expr_select, data_in}];
    assign timer_word = timer_mem[uw.jadr];
    assign case_idx   = uw.jadr + ADDR_W'(case_in);
    assign case_word  = case_mem[case_idx];
    assign pc_inc     = r_q.pc + 1'b1;

    // ************************************************************
    // Timer done flags
    // ************************************************************
    genvar t;
    generate
        for (t = 0; t < NUM_TIMERS; t++) begin : g_done
            assign done[t] = (r_q.cnt[t] == '0);
        end
    endgenerate

    // Timer done of the one selected counter, else expression result
    assign cond = uw.var_or_timer ? |(done & uw.counter_select)
                                  : expr_bit;

    // ************************************************************
    // APB decode
    // ************************************************************
    assign setup     = psel && !penable;
    assign access_wr = psel && penable && pwrite && mapped(paddr);
    assign load_wr   = access_wr && (paddr == REG_LOAD_LO);
    assign load_mem  = r_q.load_sel[LOAD_MEM_LSB +: 2];
    assign load_idx  = r_q.load_sel[LOAD_INDEX_LSB +: ADDR_W];
    assign restart   = access_wr && (paddr == REG_CTRL) &&
                       pwdata[CTRL_RESTART_BIT];
    assign push      = r_q.run && uw.jump && uw.call && !uw.ret;
    assign pop       = r_q.run && uw.ret;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        r_d = r_q;
        if (r_q.run) begin
            if (uw.ret) begin
                r_d.pc = stack_top;
            end else if (uw.jump) begin
                r_d.pc = uw.jadr;
            end else if (uw.case_target) begin
                r_d.pc = case_word;
            end else if (uw.branch && !cond) begin
                r_d.pc = uw.jadr;
            end else begin
                r_d.pc = pc_inc;
            end
            if (uw.capture) begin
                r_d.outs = (r_q.outs & ~uw.mask) |
                           (uw.state & uw.mask);
            end
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (uw.counter_load[i]) begin
                    r_d.cnt[i] = timer_word;
                end else if (uw.counter_select[i] && !done[i]) begin
                    r_d.cnt[i] = r_q.cnt[i] - 1'b1;
                end
            end
        end
        if (setup) begin
            r_d.slverr = !mapped(paddr);
            unique case (paddr)
                REG_CTRL: begin
                    r_d.rdata = 32'(r_q.run);
                end
                REG_STATUS: begin
                    r_d.rdata = (32'(r_q.pc) << STAT_PC_LSB) |
                                (32'(stack_depth) << STAT_DEPTH_LSB) |
                                (32'(r_q.run) << STAT_RUN_BIT);
                end
                REG_LOAD_SEL: begin
                    r_d.rdata = 32'(r_q.load_sel);
                end
                REG_LOAD_HI: begin
                    r_d.rdata = 32'(r_q.hi);
                end
                default: begin
                    r_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        if (access_wr) begin
            unique case (paddr)
                REG_CTRL: begin
                    r_d.run = pwdata[CTRL_RUN_BIT];
                end
                REG_LOAD_SEL: begin
                    r_d.load_sel = pwdata[LOAD_SEL_W-1:0];
                end
                REG_LOAD_HI: begin
                    r_d.hi = pwdata[HI_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (restart) begin
            r_d.pc   = '0;
            r_d.outs = STATE_RESET;
            r_d.cnt  = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q          <= '0;
            r_q.outs     <= STATE_RESET;
            r_q.run      <= RUN_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // Memory loading, one word per write of the low data register
    always_ff @(posedge pclk) begin
        if (load_wr) begin
            unique case (load_mem)
                MEM_UCODE: begin
                    ucode_mem[load_idx] <= {r_q.hi, pwdata};
                end
                MEM_EXPR: begin
                    expr_mem[load_idx] <= pwdata[0];
                end
                MEM_TIMER: begin
                    timer_mem[load_idx] <= pwdata;
                end
                MEM_CASE: begin
                    case_mem[load_idx] <= pwdata[ADDR_W-1:0];
                end
            endcase
        end
    end

    mcs_return_stack u_stack (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (restart),
        .push      (push),
        .pop       (pop),
        .push_addr (pc_inc),
        .top_addr  (stack_top),
        .depth     (stack_depth)
    );

    assign state_out = r_q.outs;
    assign case_sel  = uw.case_sel;
    assign prdata    = r_q.rdata;
    assign pready    = 1'b1;
    assign pslverr   = r_q.slverr;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic step;
    logic halt;
    logic flow_free;
    logic timer_pick;
    assign step       = r_q.run && !restart;
    assign halt       = !r_q.run && !restart;
    assign flow_free  = !uw.ret && !uw.jump && !uw.case_target;
    assign timer_pick = uw.var_or_timer &&
                        (uw.counter_select == NUM_TIMERS'(1));

    sequence s_call;
        step && uw.jump && uw.call && !uw.ret;
    endsequence

    sequence s_pushed(logic [DEPTH_W-1:0] d0, mcs_addr_type tgt);
        r_q.pc == tgt && (stack_depth == d0 + 1'b1 ||
                          d0 == DEPTH_W'(STACK_DEPTH));
    endsequence

    sequence s_false_branch;
        step && uw.branch && flow_free && !cond;
    endsequence

    sequence s_true_branch;
        step && uw.branch && flow_free && cond;
    endsequence

    sequence s_timer_wait;
        step && uw.branch && flow_free && timer_pick && !done[0];
    endsequence

    sequence s_timer_done;
        step && uw.branch && flow_free && timer_pick && done[0];
    endsequence

    chk_mask_merge: assert property (
        step && uw.capture |=>
        r_q.outs == (($past(r_q.outs) & ~$past(uw.mask)) |
                     ($past(uw.state) & $past(uw.mask))))
        else $error("Masked output merge wrong");

    chk_capture_hold: assert property (
        !(step && uw.capture) && !restart |=> $stable(r_q.outs))
        else $error("Outputs moved without capture");

    chk_branch_taken: assert property (
        s_false_branch |=> r_q.pc == $past(uw.jadr))
        else $error("False branch did not jump");

    chk_branch_fall: assert property (
        s_true_branch |=> r_q.pc == $past(pc_inc))
        else $error("True branch did not step");

    chk_timer_wait: assert property (
        s_timer_wait |=> r_q.pc == $past(uw.jadr))
        else $error("Busy timer did not hold branch");

    chk_timer_done: assert property (
        s_timer_done |=> r_q.pc == $past(pc_inc))
        else $error("Finished timer did not fall through");

    chk_forced_jump: assert property (
        step && uw.jump && !uw.ret |=> r_q.pc == $past(uw.jadr))
        else $error("Forced jump missed");

    chk_call_push: assert property (
        s_call |=> s_pushed($past(stack_depth), $past(uw.jadr)))
        else $error("Call did not push and jump");

    chk_return_pop: assert property (
        step && uw.ret && stack_depth != '0 |=>
        r_q.pc == $past(stack_top) &&
        stack_depth == $past(stack_depth) - 1'b1)
        else $error("Return did not pop top");

    chk_depth_bound: assert property (
        stack_depth <= DEPTH_W'(STACK_DEPTH))
        else $error("Stack depth beyond its size");

    chk_case_jump: assert property (
        step && uw.case_target && !uw.ret && !uw.jump |=>
        r_q.pc == $past(case_word))
        else $error("Case target not taken");

    chk_counter_load: assert property (
        step && uw.counter_load[0] |=> r_q.cnt[0] == $past(timer_word))
        else $error("Counter load wrong");

    chk_load_second: assert property (
        step && uw.counter_load[1] |=> r_q.cnt[1] == $past(timer_word))
        else $error("Second counter load wrong");

    chk_count_down: assert property (
        step && uw.counter_select[0] && !uw.counter_load[0] && !done[0]
        |=> r_q.cnt[0] == $past(r_q.cnt[0]) - 1'b1)
        else $error("Selected counter did not decrement");

    chk_count_idle: assert property (
        step && !uw.counter_select[0] && !uw.counter_load[0]
        |=> $stable(r_q.cnt[0]))
        else $error("Idle counter moved");

    chk_counter_done: assert property (
        step && uw.counter_select[0] && !uw.counter_load[0] &&
        r_q.cnt[0] == 32'h0000_0001 |=> done[0])
        else $error("Done missing at zero");

    chk_plain_step: assert property (
        step && flow_free && !uw.branch |=>
        r_q.pc == $past(r_q.pc) + 1'b1)
        else $error("Plain word did not increment");

    chk_halt_hold: assert property (
        halt |=> $stable(r_q.pc) && $stable(r_q.outs))
        else $error("Halted sequencer moved");

    chk_restart_zero: assert property (
        restart |=> r_q.pc == '0 && stack_depth == '0 &&
        r_q.outs == STATE_RESET)
        else $error("Restart state wrong");
endmodule // mcs_sequencer
`default_nettype wire

// File: inc/mcs_pkg.sv
// Constants and types shared by the microcode sequencer and its stack.
// Assumes a single 125 MHz clock and an APB master on the register side.
// How it works
// - Each output bit loads new value only where its mask bit is set.
// - Output bits change only when the capture bit of the word is 1, or on restart.
// - State and mask fields are output-count wide, in declaration order.
// - Expression select is upper table address; inputs are lower bits.
// - First declared input is the lowest expression address bit.
// - Branch jumps to target when condition false, steps on when true.
// - Condition source bit picks expression table or selected timer done.
// - Timer done asserts when its countdown counter has reached zero.
// - One-hot counter select, lsb is first counter; it counts down.
// - Load bit fills that counter from timer memory at the jump target.
// - Unconditional jump takes next address from jump target field.
// - Call with jump pushes return address and continues at jump target.
// - Return takes top of stack as next address and pops same cycle.
// - Case target bit selects case translation memory as next address.
// - Case source select is driven out; jump target is table base.
// - Case memory indexed by 8-bit case value, words hold addresses.
// - Stack depth is a build parameter; overflow is not flagged.
// - Every loop counter has one uniform width, 32 bits by default.
// - Program counter is only as wide as the microcode depth needs.
`default_nettype none
package mcs_pkg;
    localparam int NUM_STATES  = 8;
    localparam int NUM_INPUTS  = 4;
    localparam int EXPR_SEL_W  = 4;
    localparam int NUM_TIMERS  = 2;
    localparam int TIMER_W     = 32;
    localparam int UCODE_DEPTH = 256;
    localparam int ADDR_W      = $clog2(UCODE_DEPTH);
    localparam int CASE_W      = 8;
    localparam int CASE_DEPTH  = 2 ** CASE_W;
    localparam int CASE_SEL_W  = 2;
    localparam int STACK_DEPTH = 4;
    localparam int EXPR_DEPTH  = (2 ** EXPR_SEL_W) * (2 ** NUM_INPUTS);
    localparam int TIMER_DEPTH = 2 ** ADDR_W;
    localparam int DEPTH_W     = $clog2(STACK_DEPTH + 1);

    typedef logic [NUM_STATES-1:0] mcs_state_type;
    typedef logic [ADDR_W-1:0]     mcs_addr_type;
    typedef logic [NUM_INPUTS-1:0] mcs_input_type;
    typedef logic [CASE_W-1:0]     mcs_case_type;
    typedef logic [CASE_SEL_W-1:0] mcs_case_sel_type;
    typedef logic [TIMER_W-1:0]    mcs_count_type;

    // Microcode word, first field in the top bits
    typedef struct packed {
        mcs_state_type           state;
        mcs_state_type           mask;
        mcs_addr_type            jadr;
        logic [EXPR_SEL_W-1:0]   expr_select;
        logic [NUM_TIMERS-1:0]   counter_select;
        logic [NUM_TIMERS-1:0]   counter_load;
        mcs_case_sel_type        case_sel;
        logic                    case_target;
        logic                    capture;
        logic                    var_or_timer;
        logic                    branch;
        logic                    jump;
        logic                    call;
        logic                    ret;
    } mcs_uword_type;
    localparam int UWORD_W = $bits(mcs_uword_type);
    localparam int HI_W    = UWORD_W - 32;

    // Register byte offsets
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_STATUS   = 12'h004;
    localparam logic [11:0] REG_LOAD_SEL = 12'h008;
    localparam logic [11:0] REG_LOAD_LO  = 12'h00c;
    localparam logic [11:0] REG_LOAD_HI  = 12'h010;

    // Field positions
    localparam int CTRL_RUN_BIT     = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam int LOAD_INDEX_LSB   = 0;
    localparam int LOAD_MEM_LSB     = 8;
    localparam int LOAD_SEL_W       = 10;
    localparam int STAT_PC_LSB      = 0;
    localparam int STAT_DEPTH_LSB   = 8;
    localparam int STAT_RUN_BIT     = 16;

    // Memory selects for loading
    localparam logic [1:0] MEM_UCODE = 2'h0;
    localparam logic [1:0] MEM_EXPR  = 2'h1;
    localparam logic [1:0] MEM_TIMER = 2'h2;
    localparam logic [1:0] MEM_CASE  = 2'h3;

    // Reset values
    localparam mcs_state_type STATE_RESET = 8'h00;
    localparam logic          RUN_RESET   = 1'b0;
endpackage
`default_nettype wire

// File: rtl/mcs_return_stack.sv
// Return address stack of the microcode sequencer.
// Assumes push and pop are never asked for in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module mcs_return_stack (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clear,
    input  wire logic                  push,
    input  wire logic                  pop,
    input  wire mcs_pkg::mcs_addr_type push_addr,
    output logic [mcs_pkg::ADDR_W-1:0] top_addr,
    output logic [mcs_pkg::DEPTH_W-1:0] depth
);
    import mcs_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    typedef struct packed {
        logic [STACK_DEPTH-1:0][ADDR_W-1:0] entry;
        logic [SP_W-1:0]                    sp;
        logic [DEPTH_W-1:0]                 count;
    } mcs_stack_type;

    mcs_stack_type r_q;
    mcs_stack_type r_d;
    logic [SP_W-1:0] top_idx;

    // ************************************************************
    // Pointer wraps silently past the depth
    // ************************************************************
    always_comb begin
        r_d     = r_q;
        top_idx = r_q.sp - 1'b1;
        if (clear) begin
            r_d.sp    = '0;
            r_d.count = '0;
        end else if (pop) begin
            r_d.sp = top_idx;
            if (r_q.count != '0) begin
                r_d.count = r_q.count - 1'b1;
            end
        end else if (push) begin
            r_d.entry[r_q.sp] = push_addr;
            r_d.sp            = r_q.sp + 1'b1;
            if (r_q.count != DEPTH_W'(STACK_DEPTH)) begin
                r_d.count = r_q.count + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign top_addr = r_q.entry[top_idx];
    assign depth    = r_q.count;
endmodule // mcs_return_stack
`default_nettype wire

// File: testbench/mcs_data_plane.sv
// Partner model: user data-plane logic beside the microcode sequencer.
// Assumes the bench sets the input pattern; case values are fixed here.
`timescale 1ns/1ns
`default_nettype none
module mcs_data_plane (
    input  wire mcs_pkg::mcs_input_type    pattern,
    input  wire mcs_pkg::mcs_case_sel_type case_sel,
    output mcs_pkg::mcs_input_type         data_in,
    output mcs_pkg::mcs_case_type          case_in
);
    import mcs_pkg::*;
    // **********************************************
    // Case source values, one per select code
    // **********************************************
    localparam mcs_case_type CASE_VAL [4] = '{8'h11, 8'h27, 8'h03, 8'hc8};

    // Bit 0 of the pattern is the first declared input
    assign data_in = pattern;
    // Case select steers the external mux onto case_in
    assign case_in = CASE_VAL[case_sel];
endmodule // mcs_data_plane
`default_nettype wire

// File: testbench/microcode_sequencer_tb.sv
// Self-checking bench for the microcode sequencer over APB.
// Assumes mcs_pkg, the design files and the data-plane model are compiled.
`timescale 1ns/1ns
`default_nettype none
module microcode_sequencer_tb;
    import mcs_pkg::*;
    localparam logic [16:0] F_RET = 17'h1, F_CALL = 17'h2, F_JMP = 17'h4;
    localparam logic [16:0] F_BR = 17'h8, F_VT = 17'h10, F_CAP = 17'h20;
    localparam logic [16:0] F_CT = 17'h40, F_CS2 = 17'h100;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    mcs_input_type    pattern = 4'h0, data_in;
    mcs_case_type     case_in;
    mcs_state_type    state_out;
    mcs_case_sel_type case_sel;
    int err_total = 0, samples_checked = 0, cycles = 0;
    logic [3:0]    row_in [4] = '{4'h1, 4'h2, 4'he, 4'hf};
    logic [7:0]    row_pc [4] = '{8'd3, 8'd6, 8'd6, 8'd3};
    mcs_state_type row_st [4] = '{8'h15, 8'h25, 8'h25, 8'h15};
    logic [31:0]   q;
    logic          e;

    mcs_sequencer i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_in(data_in), .case_in(case_in), .state_out(state_out),
        .case_sel(case_sel));
    mcs_data_plane i_plane (.pattern(pattern), .case_sel(case_sel),
        .data_in(data_in), .case_in(case_in));

    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end
    // **********************************************
    // Bus tasks and comparison
    // **********************************************
    task automatic chk(input logic [31:0] seen, exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rq,
                       output logic re);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic        re;
        apb(1'b1, a, d, rq, re);
    endtask
    task automatic load(input logic [1:0] m, input logic [7:0] i,
                        input logic [UWORD_W-1:0] w);
        wr(REG_LOAD_SEL, {22'h0, m, i});
        if (m == MEM_UCODE) wr(REG_LOAD_HI, {{(32-HI_W){1'b0}}, w[UWORD_W-1:32]});
        wr(REG_LOAD_LO, w[31:0]);
    endtask
    function automatic logic [UWORD_W-1:0] uw(input mcs_state_type st, mk,
            input mcs_addr_type ja, input logic [16:0] ctl);
        return {st, mk, ja, ctl};
    endfunction
    task automatic run_to(input logic [7:0] pc, input mcs_state_type st);
        int n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, q, e);
            n++;
        end while (q[7:0] !== pc && n < 40);
        chk(q, {15'h0, 1'b1, 8'h0, pc}, "pc");
        chk({24'h0, state_out}, {24'h0, st}, "state");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // **********************************************
    // Main sequence
    // **********************************************
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_STATUS, 32'h0, q, e);
        chk(q, 32'h0, "reset status");
        chk({24'h0, state_out}, 32'h0, "reset out");
        chk({31'h0, pready}, 32'h1, "ready");
        $display("reset done");
        load(MEM_UCODE, 8'd0, uw(8'ha5, 8'h0f, 8'd0, F_CAP));
        load(MEM_UCODE, 8'd1, uw(8'hff, 8'hff, 8'd0, 17'h0));
        load(MEM_UCODE, 8'd2, uw(8'h00, 8'h00, 8'd6, F_BR | 17'h2000));
        load(MEM_UCODE, 8'd3, uw(8'h10, 8'hf0, 8'd3, F_CAP | F_JMP));
        load(MEM_UCODE, 8'd6, uw(8'h20, 8'hf0, 8'd6, F_CAP | F_JMP));
        for (int i = 0; i < 16; i++) load(MEM_EXPR, 8'(16 + i), 41'(i % 2));
        for (int r = 0; r < 4; r++) begin
            pattern <= row_in[r];
            wr(REG_CTRL, 32'h3);
            run_to(row_pc[r], row_st[r]);
            $display("row %0d done", r);
        end
        wr(REG_CTRL, 32'h0);
        load(MEM_UCODE, 8'd0, uw(8'h00, 8'h00, 8'd8, F_JMP));
        load(MEM_UCODE, 8'd8, uw(8'h00, 8'h00, 8'd20, F_JMP | F_CALL));
        load(MEM_UCODE, 8'd9, uw(8'h00, 8'h00, 8'h10, F_CT | F_CS2));
        load(MEM_UCODE, 8'd20, uw(8'h00, 8'h00, 8'd4, 17'h600));
        load(MEM_UCODE, 8'd21, uw(8'h00, 8'h00, 8'd21, 17'h800 | F_VT | F_BR));
        load(MEM_UCODE, 8'd22, uw(8'h00, 8'h00, 8'd0, F_RET));
        load(MEM_UCODE, 8'd30, uw(8'h80, 8'h80, 8'd30, F_CAP | F_JMP | F_CS2));
        load(MEM_TIMER, 8'd4, 41'd3);
        load(MEM_CASE, 8'h13, 41'd30);
        wr(REG_CTRL, 32'h3);
        run_to(8'd30, 8'h80);
        chk({30'h0, case_sel}, 32'h2, "case sel");
        $display("call timer case done");
        apb(1'b0, REG_CTRL, 32'h0, q, e);
        chk(q, 32'h0000_0001, "ctrl read");
        apb(1'b0, REG_LOAD_SEL, 32'h0, q, e);
        chk(q, 32'h0000_0313, "load select");
        apb(1'b0, REG_LOAD_HI, 32'h0, q, e);
        chk(q, 32'h0000_0101, "load high");
        $display("readback done");
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk({q[31:1], e}, 32'h1, "unmapped");
        $display("unmapped done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({24'h0, state_out}, 32'h0, "mid reset");
        presetn <= 1'b1;
        apb(1'b0, REG_STATUS, 32'h0, q, e);
        chk(q, 32'h0, "mid reset status");
        $display("second reset done");
        finish_test();
    end
endmodule // microcode_sequencer_tb
`default_nettype wire
